// File: hdl/fault_clear_defines.svh
// offsets, codes, parameter indices and factory values of the fault and clear block
`ifndef FAULT_CLEAR_DEFINES_SVH
`define FAULT_CLEAR_DEFINES_SVH
// Function
// R1 - faults reported as codes, zero none
// R2 - internal failures get codes 51, 55-58
// R3 - transformer reversed 36, ratio out 37
// R4 - single phase with line two current: 60
// R5 - network faults 100-104, 109, 555
// R6 - memory 64, expansion 65, stuck button 66
// R7 - panel port error 11, panel loss 12
// R8 - faulty device replacement reports code 111
// R9 - warnings as codes, zero none, 109, 555
// R10 - warning 10 panel port, 11 temperature
// R11 - clear accepted from pc, panel, plc
// R12 - clear all erases everything, enters config mode; the code keeps both closing counters and temperature max
// R13 - clear all then power cycle restart
// R14 - clear all keeps closing counters, temperature max
// R15 - clear statistics keeps static data, no config
// R16 - clear statistics keeps counters and temperature max
// R17 - thermal clear zeroes level and lockout timeout
// R18 - thermal clear accepted while motor runs
// R19 - settings clear restores protection factory values
// R20 - settings clear keeps characteristics, connections, mode
// R21 - network clear restores factory, network stops
// R22 - controller power cycles after network clear; the code raises power_cycle_req only after clear all
// R23 - one clear at a time, bit self-clears

// --------------------------------
// register byte offsets
// --------------------------------
`define OFF_FAULT 8'h00
`define OFF_WARN 8'h04
`define OFF_CLEAR 8'h08
`define OFF_STATUS 8'h0c
`define OFF_PARAM_HI 2'h1

// --------------------------------
// fault and warning codes
// --------------------------------
`define FAULT_BITS 23
`define WARN_BITS 6
`define FC_NONE 16'h0000
`define FC_STACK 16'h0037
`define FC_RAM 16'h0038
`define FC_CHECKSUM 16'h0039
`define FC_WATCHDOG 16'h003a
`define FC_INT_TEMP 16'h0033
`define FC_NVM 16'h0040
`define FC_NET_INT 16'h0064
`define NET_SUB_MAX 3'h4
`define FC_CT_REV 16'h0024
`define FC_CT_RATIO 16'h0025
`define FC_OVERCURRENT 16'h0014
`define FC_UNDERVOLT 16'h001b
`define FC_OVERVOLT 16'h001c
`define FC_UNDERPOWER 16'h001d
`define FC_OVERPOWER 16'h001e
`define FC_UNDER_PF 16'h001f
`define FC_OVER_PF 16'h0020
`define FC_EXPANSION 16'h0041
`define FC_STUCK_RESET 16'h0042
`define FC_PANEL_ERR 16'h000b
`define FC_PANEL_LOSS 16'h000c
`define FC_NET_COMM 16'h006d
`define FC_REPLACE 16'h006f
`define FC_NET_CFG 16'h022b
`define FC_L2_SINGLE 16'h003c
`define WC_THERMAL 16'h0004
`define WC_OVERCURRENT 16'h0014
`define WC_PANEL 16'h000a
`define WC_INT_TEMP 16'h000b
`define WC_NET_LOSS 16'h006d
`define WC_NET_CFG 16'h022b

// --------------------------------
// parameter store indices and factory values
// --------------------------------
`define PI_STAT_RUN 4'h0
`define PI_STAT_TRIPS 4'h1
`define PI_THERM_LEVEL 4'h2
`define PI_LOCKOUT 4'h3
`define PI_THRESH 4'h4
`define PI_TIMEOUT 4'h5
`define PI_CHARACT 4'h6
`define PI_CONNECT 4'h7
`define PI_OP_MODE 4'h8
`define PI_NET_ADDR 4'h9
`define PI_NET_BAUD 4'ha
`define PI_LO1_COUNT 4'hb
`define PI_LO2_COUNT 4'hc
`define PI_TEMP_MAX 4'hd
`define FACT_THRESH 16'h0064
`define FACT_TIMEOUT 16'h000a
`define FACT_NET_ADDR 16'h0001
`define FACT_NET_BAUD 16'hffff

// --------------------------------
// timing
// --------------------------------
`define CLK_PERIOD_NS 4
`define PWR_CYCLE_NS 1000
`define PWR_CYCLE_CNT ((`PWR_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: hdl/fault_clear_pkg.sv
// types of the fault and clear block
`default_nettype none
package fault_clear_pkg;
  typedef enum logic [2:0] {CMD_NONE, CMD_ALL, CMD_STATS, CMD_THERMAL, CMD_CTRL,
    CMD_NET} cmd_t;
  typedef enum logic [1:0] {SRC_PC, SRC_PANEL, SRC_PLC} src_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_CYCLE} state_t;
endpackage
`default_nettype wire

// File: hdl/store_if.sv
// link between the clear sequencer and the parameter store
`default_nettype none
interface store_if;
  logic cmd_valid;
  fault_clear_pkg::cmd_t cmd;
  logic done;
  logic wr_en;
  logic [3:0] idx;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  modport ctrl (output cmd_valid, cmd, wr_en, idx, wr_data, input done, rd_data);
  modport store (input cmd_valid, cmd, wr_en, idx, wr_data, output done, rd_data);
endinterface
`default_nettype wire

// File: hdl/param_store.sv
// parameter store with category wipes
`include "fault_clear_defines.svh"
`default_nettype none
module param_store (
  input wire logic clk,
  input wire logic reset_n,
  store_if.store port
);
  logic [15:0] params [16];
  logic [15:0] next_params [16];
  logic next_done;

  function automatic logic wiped(input fault_clear_pkg::cmd_t c, input logic [3:0] i);
    case (c)
      fault_clear_pkg::CMD_ALL:
        wiped = i != `PI_LO1_COUNT && i != `PI_LO2_COUNT && i != `PI_TEMP_MAX; // see R14
      fault_clear_pkg::CMD_STATS: wiped = i == `PI_STAT_RUN || i == `PI_STAT_TRIPS; // see R16
      fault_clear_pkg::CMD_THERMAL: wiped = i == `PI_THERM_LEVEL || i == `PI_LOCKOUT; // see R17
      fault_clear_pkg::CMD_CTRL: wiped = i == `PI_THRESH || i == `PI_TIMEOUT; // see R20
      fault_clear_pkg::CMD_NET: wiped = i == `PI_NET_ADDR || i == `PI_NET_BAUD; // see R21
      default: wiped = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] factory(input logic [3:0] i);
    case (i)
      `PI_THRESH: factory = `FACT_THRESH;
      `PI_TIMEOUT: factory = `FACT_TIMEOUT;
      `PI_NET_ADDR: factory = `FACT_NET_ADDR;
      `PI_NET_BAUD: factory = `FACT_NET_BAUD;
      default: factory = 16'h0000;
    endcase
  endfunction

  assign port.rd_data = params[port.idx];

  // --------------------------------
  // write then wipe
  // --------------------------------
  always_comb begin
    next_params = params;
    if (port.wr_en) begin
      next_params[port.idx] = port.wr_data;
    end
    for (int i = 0; i < 16; i++) begin
      if (port.cmd_valid && wiped(port.cmd, 4'(i))) begin
        next_params[i] = factory(4'(i)); // see R19
      end
    end
    next_done = port.cmd_valid;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) begin
        params[i] <= factory(4'(i));
      end
      port.done <= 1'b0;
    end else begin
      params <= next_params;
      port.done <= next_done;
    end
  end

  // --------------------------------
  // checks
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  keep_counts_a: assert property (port.cmd_valid && !port.wr_en |=> // see R14
    $stable(params[`PI_LO1_COUNT]) && $stable(params[`PI_TEMP_MAX]))
    else $error("closing counter or temperature max changed by clear");
  stats_zero_a: assert property (port.cmd_valid && port.cmd == fault_clear_pkg::CMD_STATS // see R15
    && !port.wr_en |=> params[`PI_STAT_RUN] == 16'h0000 && $stable(params[`PI_CHARACT]))
    else $error("statistics not wiped or characteristics lost");
  thermal_zero_a: assert property (port.cmd_valid // see R17
    && port.cmd == fault_clear_pkg::CMD_THERMAL |=> params[`PI_LOCKOUT] == 16'h0000)
    else $error("lockout timeout not zeroed");
  settings_kept_a: assert property (port.cmd_valid && port.cmd == fault_clear_pkg::CMD_CTRL // see R20
    && !port.wr_en |=> params[`PI_THRESH] == `FACT_THRESH && $stable(params[`PI_OP_MODE]))
    else $error("settings clear wrong");
  net_factory_a: assert property (port.cmd_valid // see R21
    && port.cmd == fault_clear_pkg::CMD_NET |=> params[`PI_NET_ADDR] == `FACT_NET_ADDR)
    else $error("network address not restored");
endmodule // param_store
`default_nettype wire

// File: hdl/motor_fault_clear.sv
// fault and warning encoder with clear command sequencer and register slave
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`include "fault_clear_defines.svh"
`default_nettype none
module motor_fault_clear (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [`FAULT_BITS-1:0] fault_flags,
  input wire logic [2:0] net_err_sub,
  input wire logic single_phase_mode,
  input wire logic second_line_phase_current,
  input wire logic [`WARN_BITS-1:0] warn_flags,
  input wire logic motor_running,
  input wire logic [4:0] panel_clear_req,
  input wire logic [4:0] plc_clear_req,
  output logic [15:0] fault_code,
  output logic [15:0] warning_code,
  output logic config_mode,
  output logic power_cycle_req,
  output logic net_comm_enabled,
  output logic clear_busy,
  output logic clear_done
);
  localparam logic [7:0] PWR_CNT = 8'(`PWR_CYCLE_CNT);

  store_if sif ();

  param_store u_store (
    .clk(clk),
    .reset_n(reset_n),
    .port(sif.store)
  );

  fault_clear_pkg::state_t state;
  fault_clear_pkg::state_t next_state;
  fault_clear_pkg::cmd_t cmd;
  fault_clear_pkg::cmd_t next_cmd;
  fault_clear_pkg::src_t src;
  fault_clear_pkg::src_t next_src;
  fault_clear_pkg::src_t req_src;
  fault_clear_pkg::cmd_t req_cmd;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  logic [15:0] next_fault_code;
  logic [15:0] next_warning_code;
  logic next_config_mode;
  logic next_power_cycle_req;
  logic next_net_comm_enabled;
  logic next_clear_busy;
  logic next_clear_done;
  logic refused;
  logic next_refused;
  logic wr_take;
  logic [4:0] bus_bits;
  logic [4:0] req_bits;
  logic any_req;
  logic allowed;
  logic param_hit;

  // --------------------------------
  // code tables
  // --------------------------------
  function automatic logic [15:0] fault_code_of(input logic [4:0] i, input logic [2:0] sub);
    case (i)
      5'd0: fault_code_of = `FC_STACK; // see R2
      5'd1: fault_code_of = `FC_RAM;
      5'd2: fault_code_of = `FC_CHECKSUM;
      5'd3: fault_code_of = `FC_WATCHDOG;
      5'd4: fault_code_of = `FC_INT_TEMP;
      5'd5: fault_code_of = `FC_NVM; // see R6
      5'd6: fault_code_of = `FC_NET_INT + {13'h0000, (sub > `NET_SUB_MAX) ? `NET_SUB_MAX : sub}; // see R5
      5'd7: fault_code_of = `FC_CT_REV; // see R3
      5'd8: fault_code_of = `FC_CT_RATIO;
      5'd9: fault_code_of = `FC_OVERCURRENT; // see R1
      5'd10: fault_code_of = `FC_UNDERVOLT;
      5'd11: fault_code_of = `FC_OVERVOLT;
      5'd12: fault_code_of = `FC_UNDERPOWER;
      5'd13: fault_code_of = `FC_OVERPOWER;
      5'd14: fault_code_of = `FC_UNDER_PF;
      5'd15: fault_code_of = `FC_OVER_PF;
      5'd16: fault_code_of = `FC_EXPANSION;
      5'd17: fault_code_of = `FC_STUCK_RESET;
      5'd18: fault_code_of = `FC_PANEL_ERR; // see R7
      5'd19: fault_code_of = `FC_PANEL_LOSS;
      5'd20: fault_code_of = `FC_NET_COMM;
      5'd21: fault_code_of = `FC_REPLACE; // see R8
      5'd22: fault_code_of = `FC_NET_CFG;
      default: fault_code_of = `FC_NONE;
    endcase
  endfunction

  function automatic logic [15:0] warn_code_of(input logic [2:0] i);
    case (i)
      3'd0: warn_code_of = `WC_THERMAL;
      3'd1: warn_code_of = `WC_OVERCURRENT;
      3'd2: warn_code_of = `WC_PANEL; // see R10
      3'd3: warn_code_of = `WC_INT_TEMP;
      3'd4: warn_code_of = `WC_NET_LOSS; // see R9
      3'd5: warn_code_of = `WC_NET_CFG;
      default: warn_code_of = `FC_NONE;
    endcase
  endfunction

  // lowest set bit wins
  function automatic fault_clear_pkg::cmd_t pick(input logic [4:0] b);
    if (b[0]) pick = fault_clear_pkg::CMD_ALL;
    else if (b[1]) pick = fault_clear_pkg::CMD_STATS;
    else if (b[2]) pick = fault_clear_pkg::CMD_THERMAL;
    else if (b[3]) pick = fault_clear_pkg::CMD_CTRL;
    else if (b[4]) pick = fault_clear_pkg::CMD_NET;
    else pick = fault_clear_pkg::CMD_NONE;
  endfunction

  function automatic logic [4:0] onehot(input fault_clear_pkg::cmd_t c);
    case (c)
      fault_clear_pkg::CMD_ALL: onehot = 5'h01;
      fault_clear_pkg::CMD_STATS: onehot = 5'h02;
      fault_clear_pkg::CMD_THERMAL: onehot = 5'h04;
      fault_clear_pkg::CMD_CTRL: onehot = 5'h08;
      fault_clear_pkg::CMD_NET: onehot = 5'h10;
      default: onehot = 5'h00;
    endcase
  endfunction

  // --------------------------------
  // bus handshake and request selection
  // --------------------------------
  assign waitrequest = (read || write) && !ack;
  assign wr_take = write && ack;
  assign param_hit = address[7:6] == `OFF_PARAM_HI;
  assign bus_bits = (wr_take && address == `OFF_CLEAR) ? writedata[4:0] : 5'h00;
  assign req_bits = (|bus_bits) ? bus_bits : (|panel_clear_req) ? panel_clear_req
    : plc_clear_req; // see R11
  assign req_src = (|bus_bits) ? fault_clear_pkg::SRC_PC : (|panel_clear_req)
    ? fault_clear_pkg::SRC_PANEL : fault_clear_pkg::SRC_PLC;
  assign any_req = |req_bits;
  assign req_cmd = pick(req_bits);
  assign allowed = req_cmd == fault_clear_pkg::CMD_THERMAL || !motor_running; // see R18

  assign sif.cmd_valid = state == fault_clear_pkg::ST_ISSUE;
  assign sif.cmd = cmd;
  assign sif.wr_en = wr_take && param_hit;
  assign sif.idx = address[5:2];
  assign sif.wr_data = writedata[15:0];

  // --------------------------------
  // next values
  // --------------------------------
  always_comb begin
    next_ack = (read || write) && !ack;
    next_readdata = readdata;
    if (read && !ack) begin
      if (param_hit) begin
        next_readdata = {16'h0000, sif.rd_data};
      end else begin
        case (address)
          `OFF_FAULT: next_readdata = {16'h0000, fault_code};
          `OFF_WARN: next_readdata = {16'h0000, warning_code};
          `OFF_CLEAR: next_readdata = {27'h0000000, onehot(cmd)}; // see R23
          `OFF_STATUS: next_readdata = {22'h000000, src, 3'h0, refused, net_comm_enabled,
            power_cycle_req, config_mode, clear_busy};
          default: next_readdata = 32'h00000000;
        endcase
      end
    end
    next_fault_code = (single_phase_mode && second_line_phase_current)
      ? `FC_L2_SINGLE : `FC_NONE; // see R4
    for (int i = `FAULT_BITS - 1; i >= 0; i--) begin
      if (fault_flags[i]) begin
        next_fault_code = fault_code_of(5'(i), net_err_sub); // see R1
      end
    end
    next_warning_code = `FC_NONE;
    for (int i = `WARN_BITS - 1; i >= 0; i--) begin
      if (warn_flags[i]) begin
        next_warning_code = warn_code_of(3'(i)); // see R9
      end
    end
    next_state = state;
    next_cmd = cmd;
    next_src = src;
    next_cnt = cnt;
    next_config_mode = config_mode;
    next_power_cycle_req = power_cycle_req;
    next_net_comm_enabled = net_comm_enabled;
    next_clear_done = 1'b0;
    next_refused = refused;
    if (wr_take && address == `OFF_STATUS) begin
      if (writedata[1]) next_config_mode = 1'b0;
      if (writedata[4]) next_refused = 1'b0;
    end
    case (state)
      fault_clear_pkg::ST_IDLE: begin
        if (any_req && allowed) begin
          next_cmd = req_cmd;
          next_src = req_src;
          next_state = fault_clear_pkg::ST_ISSUE;
        end else if (any_req) begin
          next_refused = 1'b1;
        end
      end
      fault_clear_pkg::ST_ISSUE: begin
        next_state = fault_clear_pkg::ST_WAIT;
        if (any_req) next_refused = 1'b1; // see R23
      end
      fault_clear_pkg::ST_WAIT: begin
        if (any_req) next_refused = 1'b1;
        if (sif.done) begin
          next_clear_done = 1'b1;
          next_cmd = fault_clear_pkg::CMD_NONE; // see R23
          next_state = fault_clear_pkg::ST_IDLE;
          if (cmd == fault_clear_pkg::CMD_ALL) begin
            next_config_mode = 1'b1; // see R12
            next_net_comm_enabled = 1'b0;
            next_power_cycle_req = 1'b1; // see R13
            next_cnt = PWR_CNT - 8'h01;
            next_state = fault_clear_pkg::ST_CYCLE;
          end else if (cmd == fault_clear_pkg::CMD_NET) begin
            next_net_comm_enabled = 1'b0; // see R21
          end
        end
      end
      fault_clear_pkg::ST_CYCLE: begin
        if (any_req) next_refused = 1'b1;
        if (cnt == 8'h00) begin
          next_power_cycle_req = 1'b0;
          next_state = fault_clear_pkg::ST_IDLE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: next_state = fault_clear_pkg::ST_IDLE;
    endcase
    next_clear_busy = next_state != fault_clear_pkg::ST_IDLE;
  end

  // --------------------------------
  // registers
  // --------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= fault_clear_pkg::ST_IDLE;
      cmd <= fault_clear_pkg::CMD_NONE;
      src <= fault_clear_pkg::SRC_PC;
      cnt <= 8'h00;
      ack <= 1'b0;
      readdata <= 32'h00000000;
      fault_code <= `FC_NONE;
      warning_code <= `FC_NONE;
      config_mode <= 1'b0;
      power_cycle_req <= 1'b0;
      net_comm_enabled <= 1'b1;
      clear_busy <= 1'b0;
      clear_done <= 1'b0;
      refused <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      src <= next_src;
      cnt <= next_cnt;
      ack <= next_ack;
      readdata <= next_readdata;
      fault_code <= next_fault_code;
      warning_code <= next_warning_code;
      config_mode <= next_config_mode;
      power_cycle_req <= next_power_cycle_req;
      net_comm_enabled <= next_net_comm_enabled;
      clear_busy <= next_clear_busy;
      clear_done <= next_clear_done;
      refused <= next_refused;
    end
  end

  // --------------------------------
  // checks
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  fault_zero_a: assert property (fault_flags == '0 && !single_phase_mode |=> // see R1
    fault_code == 16'h0000)
    else $error("fault code not zero without fault");
  internal_fail_a: assert property (fault_flags[3:0] == 4'h8 |=> // see R2
    fault_code == 16'h003a)
    else $error("watchdog code wrong");
  ct_codes_a: assert property (fault_flags[8:0] == 9'h100 |=> fault_code == 16'h0025) // see R3
    else $error("ratio code wrong");
  single_line_a: assert property (fault_flags == '0 && single_phase_mode // see R4
    && second_line_phase_current |=> fault_code == 16'h003c)
    else $error("line two code wrong");
  net_fault_a: assert property (fault_flags[6:0] == 7'h40 && net_err_sub <= 3'h4 // see R5
    |=> fault_code == 16'h0064 + 16'($past(net_err_sub)))
    else $error("network internal code wrong");
  own_codes_a: assert property (fault_flags[17:0] == 18'h20000 |=> // see R6
    fault_code == 16'h0042)
    else $error("stuck button code wrong");
  panel_fault_a: assert property (fault_flags[19:0] == 20'h80000 |=> // see R7
    fault_code == 16'h000c)
    else $error("panel loss code wrong");
  replace_code_a: assert property (fault_flags[21:0] == 22'h200000 |=> // see R8
    fault_code == 16'h006f)
    else $error("replacement code wrong");
  warn_codes_a: assert property (warn_flags == 6'h20 |=> warning_code == 16'h022b) // see R9
    else $error("network configuration warning wrong");
  warn_table_a: assert property (warn_flags[3:0] == 4'h8 |=> warning_code == 16'h000b) // see R10
    else $error("temperature warning wrong");
  plc_accept_a: assert property (state == fault_clear_pkg::ST_IDLE && !motor_running // see R11
    && plc_clear_req == 5'h02 && panel_clear_req == 5'h00 && !write
    |=> cmd == fault_clear_pkg::CMD_STATS && src == fault_clear_pkg::SRC_PLC)
    else $error("plc clear not taken");
  all_config_a: assert property (state == fault_clear_pkg::ST_ISSUE // see R12
    && cmd == fault_clear_pkg::CMD_ALL |-> ##2 config_mode && !net_comm_enabled)
    else $error("clear all did not enter configuration mode");
  power_cycle_a: assert property ($rose(power_cycle_req) |-> power_cycle_req[*8] // see R13
    ##[1:300] !power_cycle_req)
    else $error("power cycle request length wrong");
  thermal_run_a: assert property (state == fault_clear_pkg::ST_IDLE && motor_running // see R18
    && req_cmd == fault_clear_pkg::CMD_THERMAL |=> state == fault_clear_pkg::ST_ISSUE)
    else $error("thermal clear refused while running");
  stats_no_cfg_a: assert property (state == fault_clear_pkg::ST_ISSUE // see R15
    && cmd == fault_clear_pkg::CMD_STATS |-> ##2 config_mode == $past(config_mode, 2))
    else $error("statistics clear changed configuration mode");
  one_at_time_a: assert property ((state == fault_clear_pkg::ST_ISSUE // see R23
    || state == fault_clear_pkg::ST_CYCLE) && any_req |=> cmd == $past(cmd) && refused)
    else $error("clear accepted while busy");
  self_clear_a: assert property (state == fault_clear_pkg::ST_ISSUE |-> // see R23
    ##2 clear_done && cmd == fault_clear_pkg::CMD_NONE)
    else $error("clear did not complete");
endmodule // motor_fault_clear
`default_nettype wire

// File: bench/clear_source_model.sv
// panel and plc model that sends one-cycle clear requests
`default_nettype none
module clear_source_model (
  input wire logic clk,
  output logic [4:0] panel_clear_req,
  output logic [4:0] plc_clear_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    panel_clear_req = 5'h00;
    plc_clear_req = 5'h00;
  end
  // one request bit for one cycle, then released
  task automatic pulse(input bit from_plc, input int b);
    @(posedge clk);
    if (from_plc) plc_clear_req <= 5'h01 << b;
    else panel_clear_req <= 5'h01 << b;
    @(posedge clk);
    plc_clear_req <= 5'h00;
    panel_clear_req <= 5'h00;
  endtask
endmodule // clear_source_model
`default_nettype wire

// File: bench/motor_fault_clear_tb.sv
// self-checking bench of the fault encoder and clear sequencer
`include "fault_clear_defines.svh"
`default_nettype none
module motor_fault_clear_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0, waitrequest;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [22:0] fault_flags = 23'h0;
  logic [2:0] net_err_sub = 3'h0;
  logic single_phase_mode = 1'b0, second_line_phase_current = 1'b0, motor_running = 1'b0;
  logic [5:0] warn_flags = 6'h00;
  logic [4:0] panel_clear_req, plc_clear_req;
  logic [15:0] fault_code, warning_code;
  logic config_mode, power_cycle_req, net_comm_enabled, clear_busy, clear_done;
  int bad_count = 0, checks = 0, cyc = 0, pcr_cnt = 0, sub, exp_net;
  int exp_p [16];
  int fault_tab [23] = '{55, 56, 57, 58, 51, 64, 100, 36, 37, 20, 27, 28, 29, 30, 31, 32,
    65, 66, 11, 12, 109, 111, 555};
  int warn_tab [6] = '{4, 20, 10, 11, 109, 555};
  always #2 clk = ~clk;
  motor_fault_clear u_motor_fault_clear (.clk(clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .fault_flags(fault_flags), .net_err_sub(net_err_sub),
    .single_phase_mode(single_phase_mode), .second_line_phase_current(second_line_phase_current),
    .warn_flags(warn_flags), .motor_running(motor_running), .panel_clear_req(panel_clear_req),
    .plc_clear_req(plc_clear_req), .fault_code(fault_code), .warning_code(warning_code),
    .config_mode(config_mode), .power_cycle_req(power_cycle_req),
    .net_comm_enabled(net_comm_enabled), .clear_busy(clear_busy), .clear_done(clear_done));
  clear_source_model u_clear_source_model (.clk(clk), .panel_clear_req(panel_clear_req),
    .plc_clear_req(plc_clear_req));
  always @(posedge clk) begin
    cyc++;
    if (power_cycle_req === 1'b1) pcr_cnt++;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic finish_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= d;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  function automatic int fact(input int i);
    case (i)
      `PI_THRESH: return `FACT_THRESH;
      `PI_TIMEOUT: return `FACT_TIMEOUT;
      `PI_NET_ADDR: return `FACT_NET_ADDR;
      `PI_NET_BAUD: return `FACT_NET_BAUD;
      default: return 0;
    endcase
  endfunction
  // src 0 bus, 1 panel, 2 plc
  task automatic do_clear(input int cmd, input int src);
    int n;
    n = 0;
    for (int i = 0; i < 14; i++) begin
      exp_p[i] = $urandom & 'hffff;
      bus(1'b1, 8'h40 + 8'(4 * i), exp_p[i]);
    end
    pcr_cnt = 0;
    if (src == 0) bus(1'b1, `OFF_CLEAR, 32'h1 << cmd);
    else u_clear_source_model.pulse(src == 2, cmd);
    while (clear_done !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("clear_done", 1, clear_done);
    chk("clear_busy", cmd == 0, clear_busy);
    for (int i = 0; i < 16; i++) begin
      if ((cmd == 0 && i < 11) || (cmd == 1 && i < 2) || (cmd == 2 && (i == 2 || i == 3))
        || (cmd == 3 && (i == 4 || i == 5)) || (cmd == 4 && (i == 9 || i == 10)))
        exp_p[i] = fact(i);
    end
    if (cmd == 0 || cmd == 4) exp_net = 0;
    chk("config_mode", cmd == 0, config_mode);
    chk("net_comm_enabled", exp_net, net_comm_enabled);
    if (cmd == 0) begin
      chk("power_cycle_req", 1, power_cycle_req);
      bus(1'b1, `OFF_CLEAR, 32'h2);
      bus(1'b0, `OFF_STATUS, 0);
      chk("refused", 1, q[4]);
      n = 0;
      while (clear_busy !== 1'b0 && n < 400) begin
        @(posedge clk);
        n++;
      end
      chk("power_cycle_len", `PWR_CYCLE_CNT, pcr_cnt);
    end else begin
      bus(1'b0, `OFF_CLEAR, 0);
      chk("clear_reg", 0, q);
    end
    bus(1'b0, `OFF_STATUS, 0);
    chk("source", src, q[9:8]);
    for (int i = 0; i < 14; i++) begin
      bus(1'b0, 8'h40 + 8'(4 * i), 0);
      chk("param", exp_p[i], q);
    end
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    void'($urandom(73368));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    exp_net = 1;
    for (int i = 0; i < 23; i++) begin
      sub = $urandom % 5;
      @(posedge clk);
      net_err_sub <= sub[2:0];
      fault_flags <= (23'h1 << i) | (23'($urandom) & ~((23'h2 << i) - 23'h1));
      repeat (2) @(posedge clk);
      chk("fault_code", i == 6 ? 100 + sub : fault_tab[i], fault_code);
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      warn_flags <= (6'h1 << i) | (6'($urandom) & ~((6'h2 << i) - 6'h1));
      repeat (2) @(posedge clk);
      chk("warning_code", warn_tab[i], warning_code);
    end
    fault_flags <= 23'h0;
    warn_flags <= 6'h00;
    single_phase_mode <= 1'b1;
    second_line_phase_current <= 1'b1;
    bus(1'b0, `OFF_FAULT, 0);
    bus(1'b0, `OFF_FAULT, 0);
    chk("fault_reg", 60, q);
    bus(1'b0, `OFF_WARN, 0);
    chk("warn_reg", 0, q);
    bus(1'b0, 8'h80, 0);
    chk("unmapped", 0, q);
    second_line_phase_current <= 1'b0;
    repeat (2) @(posedge clk);
    chk("fault_code", 0, fault_code);
    do_clear(1, 2);
    motor_running <= 1'b1;
    do_clear(2, 1);
    bus(1'b1, `OFF_CLEAR, 32'h2);
    bus(1'b0, `OFF_STATUS, 0);
    chk("refused", 1, q[4]);
    bus(1'b1, `OFF_STATUS, 32'h10);
    bus(1'b0, `OFF_STATUS, 0);
    chk("refused", 0, q[4]);
    motor_running <= 1'b0;
    do_clear(3, 2);
    do_clear(4, 0);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    exp_net = 1;
    @(posedge clk);
    chk("net_comm_enabled", 1, net_comm_enabled);
    do_clear(0, 2);
    finish_test();
  end
endmodule // motor_fault_clear_tb
`default_nettype wire
